// file: hdl/info_responder.sv
`timescale 1ns/1ps
`include "info_resp_map.svh"

module info_responder
  import info_resp_pkg::*;
#(
  parameter int PROTO_COUNT = 2,
  parameter logic [8*PROTO_COUNT-1:0] PROTO_LIST = {8'h01, 8'h00},
  parameter int CERT_DEPTH = 1024,
  parameter int COMP_DEPTH = 1024,
  parameter logic [15:0] DESC_TYPE = 16'h0001,
  parameter int PAD_UNIT = 4,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_protocol,
  input wire logic [15:0] cmd_specific,
  input wire logic [31:0] cmd_alloc_len,
  input wire logic comp_enable,
  input wire logic [15:0] cert_len,
  input wire logic cert_wr_en,
  input wire logic [15:0] cert_wr_addr,
  input wire logic [7:0] cert_wr_data,
  input wire logic [15:0] comp_body_len,
  input wire logic comp_wr_en,
  input wire logic [15:0] comp_wr_addr,
  input wire logic [7:0] comp_wr_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic sts_valid,
  output logic sts_check
);
  // ****************************************
  // Storage and state
  // ****************************************
  localparam logic [31:0] PAD_MASK = 32'(PAD_UNIT - 1);
  localparam int CERT_AW = $clog2(CERT_DEPTH);
  localparam int COMP_AW = $clog2(COMP_DEPTH);

  logic [7:0] cert_mem [CERT_DEPTH];
  logic [7:0] comp_mem [COMP_DEPTH];

  state_t state_q;
  mode_t mode_q;
  logic [31:0] idx_q;
  logic [31:0] total_q;
  logic [31:0] limit_q;
  logic [15:0] cert_len_q;
  logic [15:0] comp_len_q;
  logic sts_valid_q;
  logic sts_check_q;

  logic accept;
  logic spec_ok;
  logic [31:0] total_d;
  logic [31:0] padded_d;
  logic [31:0] limit_d;
  mode_t mode_d;
  logic [7:0] byte_d;
  logic wr_valid;
  logic wr_ready;
  logic wr_fire;
  logic wr_last;
  logic [31:0] comp_info_len;
  logic [31:0] desc_off;

  // ****************************************
  // Content stores
  // ****************************************
  // Software loads DER-encoded certificates back to back
  always_ff @(posedge ref_clk) begin
    if (ce && cert_wr_en) begin
      cert_mem[cert_wr_addr[$clog2(CERT_DEPTH)-1:0]] <= cert_wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && comp_wr_en) begin
      comp_mem[comp_wr_addr[$clog2(COMP_DEPTH)-1:0]] <= comp_wr_data;
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd_ready = (state_q == ST_IDLE);
  assign accept = ce && cmd_valid && cmd_ready;

  always_comb begin
    spec_ok = 1'b1;
    mode_d = MODE_LIST;
    case (cmd_specific)
      `SPEC_LIST: mode_d = MODE_LIST;
      `SPEC_CERT: mode_d = MODE_CERT;
      `SPEC_COMP: begin
        mode_d = MODE_COMP;
        spec_ok = comp_enable;
      end
      default: spec_ok = 1'b0;
    endcase
    if (cmd_protocol != `PROTO_INFO) begin
      spec_ok = 1'b0;
    end
  end

  // Lengths come from live inputs only, never from a prior command
  always_comb begin
    total_d = `LIST_BODY + 32'(PROTO_COUNT);
    case (mode_d)
      MODE_LIST: total_d = `LIST_BODY + 32'(PROTO_COUNT);
      MODE_CERT: total_d = `CERT_BODY + {16'h0000, cert_len};
      MODE_COMP: total_d = `COMP_DESC + `DESC_HDR_LEN + {16'h0000, comp_body_len};
      default: total_d = `LIST_BODY + 32'(PROTO_COUNT);
    endcase
    padded_d = (total_d + PAD_MASK) & ~PAD_MASK;
    limit_d = (cmd_alloc_len < padded_d) ? cmd_alloc_len : padded_d;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign wr_valid = (state_q == ST_RUN);
  assign wr_fire = ce && wr_valid && wr_ready;
  assign wr_last = (idx_q + 32'h0000_0001 == limit_q);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            if (spec_ok && limit_d != 32'h0000_0000) begin
              state_q <= ST_RUN;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_RUN: begin
          if (wr_fire && wr_last) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Nothing survives from one query to the next
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      idx_q <= 32'h0000_0000;
      mode_q <= MODE_LIST;
      total_q <= 32'h0000_0000;
      limit_q <= 32'h0000_0000;
      cert_len_q <= 16'h0000;
      comp_len_q <= 16'h0000;
    end else if (ce) begin
      if (accept) begin
        idx_q <= 32'h0000_0000;
        mode_q <= mode_d;
        total_q <= total_d;
        limit_q <= limit_d;
        cert_len_q <= cert_len;
        comp_len_q <= comp_body_len;
      end else if (wr_fire) begin
        idx_q <= idx_q + 32'h0000_0001;
      end
    end
  end

  // Status pulse: one cycle, on reject, on an accept with zero length limit, or once the last byte is queued
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sts_valid_q <= 1'b0;
      sts_check_q <= 1'b0;
    end else if (ce) begin
      sts_valid_q <= (accept && (!spec_ok || limit_d == 32'h0000_0000))
                     || (wr_fire && wr_last);
      sts_check_q <= accept && !spec_ok;
    end
  end

  assign sts_valid = sts_valid_q;
  assign sts_check = sts_check_q;

  // ****************************************
  // Byte builder
  // ****************************************
  assign comp_info_len = `DESC_HDR_LEN + {16'h0000, comp_len_q};
  assign desc_off = idx_q - `COMP_DESC;

  always_comb begin
    byte_d = `PAD_VALUE;
    if (idx_q < total_q) begin
      case (mode_q)
        MODE_LIST: begin
          if (idx_q == `LIST_LEN_HI) begin
            byte_d = 8'(PROTO_COUNT >> 8);
          end else if (idx_q == `LIST_LEN_LO) begin
            byte_d = 8'(PROTO_COUNT);
          end else if (idx_q >= `LIST_BODY) begin
            for (int i = 0; i < PROTO_COUNT; i++) begin
              if (idx_q - `LIST_BODY == 32'(i)) begin
                byte_d = PROTO_LIST[8*i +: 8];
              end
            end
          end
        end
        MODE_CERT: begin
          if (idx_q == `CERT_LEN_HI) begin
            byte_d = cert_len_q[15:8];
          end else if (idx_q == `CERT_LEN_LO) begin
            byte_d = cert_len_q[7:0];
          end else if (idx_q >= `CERT_BODY) begin
            byte_d = cert_mem[CERT_AW'(idx_q - `CERT_BODY)];
          end
        end
        MODE_COMP: begin
          if (idx_q < `COMP_DESC) begin
            byte_d = comp_info_len[8*(3 - idx_q[1:0]) +: 8];
          end else if (desc_off == `DESC_TYPE_HI) begin
            byte_d = DESC_TYPE[15:8];
          end else if (desc_off == `DESC_TYPE_LO) begin
            byte_d = DESC_TYPE[7:0];
          end else if (desc_off >= `DESC_LEN_B0 && desc_off < `DESC_BODY) begin
            byte_d = 8'(comp_len_q >> (8 * (3 - desc_off[1:0])));
          end else if (desc_off >= `DESC_BODY) begin
            byte_d = comp_mem[COMP_AW'(desc_off - `DESC_BODY)];
          end
        end
        default: byte_d = `PAD_VALUE;
      endcase
    end
  end

  // ****************************************
  // Output buffer
  // ****************************************
  // Back-pressure from the link stalls the byte counter only once the FIFO is full
  resp_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_last, byte_d}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_last, out_data})
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_good_accept;
    accept && spec_ok && limit_d != 32'h0000_0000;
  endsequence

  sequence s_stream_open;
    ##1 (state_q == ST_RUN && idx_q == 32'h0000_0000);
  endsequence

  property p_from_zero;
    @(posedge ref_clk) disable iff (!nrst)
      s_good_accept |-> s_stream_open;
  endproperty
  a_from_zero: assert property (p_from_zero) else $error("stream not at byte 0");

  property p_reject;
    @(posedge ref_clk) disable iff (!nrst)
      (accept && !spec_ok) |=> (sts_valid && sts_check && state_q == ST_DONE);
  endproperty
  a_reject: assert property (p_reject) else $error("reserved value not rejected");

  property p_no_data_on_check;
    @(posedge ref_clk) disable iff (!nrst)
      (accept && !spec_ok) |=> !wr_valid [*2];
  endproperty
  a_no_data_on_check: assert property (p_no_data_on_check) else $error("data after reject");

  property p_list_first;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && mode_q == MODE_LIST && idx_q == `LIST_BODY) |-> byte_d == 8'h00;
  endproperty
  a_list_first: assert property (p_list_first) else $error("first list entry not 00h");

  property p_list_len;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && mode_q == MODE_LIST && idx_q == `LIST_LEN_LO)
        |-> byte_d == 8'(PROTO_COUNT);
  endproperty
  a_list_len: assert property (p_list_len) else $error("bad list length");

  property p_pad_zero;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && idx_q >= total_q) |-> byte_d == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("non-zero pad byte");

  property p_cert_len;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && mode_q == MODE_CERT && idx_q == `CERT_LEN_LO)
        |-> byte_d == cert_len_q[7:0] && total_q == `CERT_BODY + {16'h0000, cert_len_q};
  endproperty
  a_cert_len: assert property (p_cert_len) else $error("bad certificate length");

  property p_comp_len;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && mode_q == MODE_COMP && idx_q == 32'h0000_0003)
        |-> byte_d == comp_info_len[7:0];
  endproperty
  a_comp_len: assert property (p_comp_len) else $error("bad compliance length");

  property p_desc_type;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_fire && mode_q == MODE_COMP && idx_q == `COMP_DESC)
        |-> byte_d == DESC_TYPE[15:8];
  endproperty
  a_desc_type: assert property (p_desc_type) else $error("bad descriptor type");

  property p_trunc;
    @(posedge ref_clk) disable iff (!nrst)
      wr_fire |-> (idx_q < limit_q && limit_q <= total_q + PAD_MASK);
  endproperty
  a_trunc: assert property (p_trunc) else $error("byte past allocation length");
endmodule

// file: include/info_resp_map.svh
`ifndef INFO_RESP_MAP_SVH
`define INFO_RESP_MAP_SVH

// ****************************************
// Command decode values
// ****************************************
`define PROTO_INFO 8'h00
`define SPEC_LIST 16'h0000
`define SPEC_CERT 16'h0001
`define SPEC_COMP 16'h0002

// ****************************************
// Supported protocol list layout
// ****************************************
`define LIST_LEN_HI 32'h0000_0006
`define LIST_LEN_LO 32'h0000_0007
`define LIST_BODY 32'h0000_0008

// ****************************************
// Certificate layout
// ****************************************
`define CERT_LEN_HI 32'h0000_0002
`define CERT_LEN_LO 32'h0000_0003
`define CERT_BODY 32'h0000_0004

// ****************************************
// Compliance layout
// ****************************************
`define COMP_LEN_B0 32'h0000_0000
`define COMP_DESC 32'h0000_0004
`define DESC_HDR_LEN 32'h0000_0008
`define DESC_TYPE_HI 32'h0000_0000
`define DESC_TYPE_LO 32'h0000_0001
`define DESC_LEN_B0 32'h0000_0004
`define DESC_BODY 32'h0000_0008
`define PAD_VALUE 8'h00

`endif

// file: include/info_resp_pkg.sv
package info_resp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  typedef enum logic [2:0] {
    MODE_LIST = 3'b001,
    MODE_CERT = 3'b010,
    MODE_COMP = 3'b100
  } mode_t;

endpackage

// file: hdl/resp_fifo.sv
`timescale 1ns/1ps

module resp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap by compare so DEPTH need not be a power of two
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// file: tb/initiator_sink.sv
`timescale 1ns/1ps

// ****************************************
// Initiator side: takes the returned bytes
// ****************************************
module initiator_sink (
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic slow,
  input wire logic hold,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last
);
  logic [7:0] got_data[$];
  logic got_last[$];
  logic [1:0] phase_q;

  initial begin
    out_ready = 1'b0;
    phase_q = 2'h0;
  end

  // Ready moves off the sampling edge; slow mode takes one byte in four
  always @(negedge ref_clk) begin
    phase_q <= phase_q + 2'h1;
    out_ready <= !hold && (!slow || phase_q == 2'h0);
  end

  always @(posedge ref_clk) begin
    if (ce && out_valid && out_ready) begin
      got_data.push_back(out_data);
      got_last.push_back(out_last);
    end
  end
endmodule

// file: tb/test_security_protocol_info_responder.sv
`timescale 1ns/1ps

module test_security_protocol_info_responder;
  logic ref_clk;
  logic nrst;
  logic ce;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_protocol;
  logic [15:0] cmd_specific;
  logic [31:0] cmd_alloc_len;
  logic comp_enable;
  logic [15:0] cert_len;
  logic cert_wr_en;
  logic [15:0] cert_wr_addr;
  logic [7:0] cert_wr_data;
  logic [15:0] comp_body_len;
  logic comp_wr_en;
  logic [15:0] comp_wr_addr;
  logic [7:0] comp_wr_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  logic out_last;
  logic sts_valid;
  logic sts_check;
  logic slow;
  logic hold;
  int n_mismatch;
  int compares;
  int cycles;
  logic [7:0] exp_q[$];

  info_responder info_responder_i (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_protocol(cmd_protocol), .cmd_specific(cmd_specific), .cmd_alloc_len(cmd_alloc_len),
    .comp_enable(comp_enable), .cert_len(cert_len), .cert_wr_en(cert_wr_en),
    .cert_wr_addr(cert_wr_addr), .cert_wr_data(cert_wr_data), .comp_body_len(comp_body_len),
    .comp_wr_en(comp_wr_en), .comp_wr_addr(comp_wr_addr), .comp_wr_data(comp_wr_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .sts_valid(sts_valid), .sts_check(sts_check)
  );

  initiator_sink initiator_sink_i (
    .ref_clk(ref_clk), .ce(ce), .slow(slow), .hold(hold), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Reporting
  // ****************************************
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Hang guard: the whole sequence needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic push_pad(input int unit);
    while (exp_q.size() % unit != 0) exp_q.push_back(8'h00);
  endtask

  task automatic write_store(input logic to_cert, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      cert_wr_en = to_cert;
      comp_wr_en = !to_cert;
      cert_wr_addr = 16'(i);
      comp_wr_addr = 16'(i);
      cert_wr_data = 8'(i * 7 + 3);
      comp_wr_data = 8'(i * 7 + 3);
    end
    @(negedge ref_clk);
    cert_wr_en = 1'b0;
    comp_wr_en = 1'b0;
  endtask

  task automatic run_cmd(input logic [7:0] proto, input logic [15:0] spec,
      input logic [31:0] alloc, input logic exp_chk);
    int n;
    initiator_sink_i.got_data.delete();
    initiator_sink_i.got_last.delete();
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_protocol = proto;
    cmd_specific = spec;
    cmd_alloc_len = alloc;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check1(cmd_ready, 1'b1, "ready before command");
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    check1(cmd_ready, 1'b0, "ready during command");
    n = 0;
    while (sts_valid !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    check1(sts_valid, 1'b1, "status pulse");
    check1(sts_check, exp_chk, "check condition");
    n = 0;
    while (initiator_sink_i.got_data.size() < exp_q.size() && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    // Extra cycles expose any byte beyond the expected end
    repeat (12) @(negedge ref_clk);
    check8(8'(initiator_sink_i.got_data.size()), 8'(exp_q.size()), "byte count");
    foreach (exp_q[i]) begin
      if (i < initiator_sink_i.got_data.size()) begin
        check8(initiator_sink_i.got_data[i], exp_q[i], "data byte");
        check1(initiator_sink_i.got_last[i], i == exp_q.size() - 1, "last flag");
      end
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_list();
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01};
    push_pad(4);
    run_cmd(8'h00, 16'h0000, 32'd100, 1'b0);
    exp_q = exp_q[0:8];
    run_cmd(8'h00, 16'h0000, 32'd9, 1'b0);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01};
    push_pad(4);
    run_cmd(8'h00, 16'h0000, 32'd100, 1'b0);
  endtask

  task automatic t_cert_stalled();
    write_store(1'b1, 37);
    cert_len = 16'h0025;
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h25};
    for (int i = 0; i < 37; i++) exp_q.push_back(8'(i * 7 + 3));
    push_pad(4);
    // Sink refuses long enough to fill the FIFO, then trickles
    hold = 1'b1;
    slow = 1'b1;
    fork
      begin
        repeat (60) @(negedge ref_clk);
        hold = 1'b0;
      end
    join_none
    run_cmd(8'h00, 16'h0001, 32'd1000, 1'b0);
    slow = 1'b0;
  endtask

  task automatic t_cert_empty();
    cert_len = 16'h0000;
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
    run_cmd(8'h00, 16'h0001, 32'd100, 1'b0);
  endtask

  task automatic t_comp();
    write_store(1'b0, 3);
    comp_enable = 1'b1;
    comp_body_len = 16'h0003;
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h01, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h0A, 8'h11};
    push_pad(4);
    // Clock enable dropped mid-stream: nothing lost, nothing repeated
    fork
      begin
        repeat (6) @(negedge ref_clk);
        ce = 1'b0;
        repeat (5) @(negedge ref_clk);
        ce = 1'b1;
      end
    join_none
    run_cmd(8'h00, 16'h0002, 32'd100, 1'b0);
  endtask

  task automatic t_refuse();
    logic [7:0] protos[4] = '{8'h01, 8'h00, 8'h00, 8'h00};
    logic [15:0] specs[4] = '{16'h0000, 16'h0003, 16'hFFFF, 16'h0002};
    exp_q.delete();
    comp_enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k == 3) comp_enable = 1'b0;
      run_cmd(protos[k], specs[k], 32'd100, 1'b1);
    end
  endtask

  initial begin
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    nrst = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_protocol = 8'h00;
    cmd_specific = 16'h0000;
    cmd_alloc_len = 32'h0000_0000;
    comp_enable = 1'b0;
    cert_len = 16'h0000;
    cert_wr_en = 1'b0;
    cert_wr_addr = 16'h0000;
    cert_wr_data = 8'h00;
    comp_body_len = 16'h0000;
    comp_wr_en = 1'b0;
    comp_wr_addr = 16'h0000;
    comp_wr_data = 8'h00;
    slow = 1'b0;
    hold = 1'b0;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    t_list();
    t_cert_stalled();
    t_cert_empty();
    t_comp();
    t_refuse();
    complete_run();
  end
endmodule
